// ===== rtl/sadc_device_end.sv
/*
 * Converter end: framing, serial result, track/hold and power mode.
 * Assumes link pins come asynchronously from the host; sample is a
 * 12-bit code presented by the analog core, read at frame start.
 */
// Function
// - Frame start: drive output, sample, hold
// - Return to track at 13th rise
// - Host waits 350ns after 13th rise
// - Float output after 16th fall or deselect
// - Host waits quiet interval between frames
// - Sixteen clocks; shift out on falls
// - Three zeros then twelve bits, MSB first
// - Early select may add a fourth zero
// - Host spaces frame starts by minimum time
// - Host uses twenty-clock frames for throughput
// - Straight binary code, step supply/4096
// - Select low enters normal, starts conversion
// - Early deselect before tenth fall: shutdown
// - Shutdown holds until next select low
// - Deselect 10th to 16th: abort, stay normal
// - Host raises select before next frame
// - Deselect before second fall: no mode change
// - Wake frame ended early returns to shutdown
// - First conversion after wake is dummy
// - Host does dummy conversion after power-up
`timescale 1ns/1ps
`default_nettype none
module sadc_device_end (
    input  wire logic        clk,
    input  wire logic        arst_n,
    sadc_if.device           link,
    input  wire logic [11:0] sample_code,
    output var  logic        holding,
    output var  logic        shutdown,
    output var  logic        dummy_frame
);
    // ============================================================
    // Pin synchronisers
    logic sel_n_lvl;
    logic sel_rise;
    logic sel_fall;
    logic sclk_lvl;
    logic sclk_rise;
    logic sclk_fall;

    sadc_pin_sync #(.RST_VAL(1'b1)) u_sel (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (link.frame_sel_n),
        .level  (sel_n_lvl),
        .rise   (sel_rise),
        .fall   (sel_fall)
    );

    // Link clock idles high; matching reset value avoids a false edge
    sadc_pin_sync #(.RST_VAL(1'b1)) u_sclk (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (link.sclk),
        .level  (sclk_lvl),
        .rise   (sclk_rise),
        .fall   (sclk_fall)
    );

    // ============================================================
    // Edge counters within a frame
    logic [4:0]  rise_cnt_r;
    logic [4:0]  fall_cnt_r;
    logic        active_r;
    logic [15:0] shift_r;
    logic        out_r;
    logic        oe_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rise_cnt_r <= '0;
        end else if (sel_fall) begin
            rise_cnt_r <= '0;
        end else if (active_r && sclk_rise && rise_cnt_r != sadc_pkg::LAST_FALL) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
        end
    end

    // Saturates so a long idle-low select cannot wrap into a new frame
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fall_cnt_r <= '0;
        end else if (sel_fall) begin
            fall_cnt_r <= '0;
        end else if (active_r && sclk_fall && fall_cnt_r != sadc_pkg::LAST_FALL) begin
            fall_cnt_r <= fall_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            active_r <= 1'b0;
        else if (sel_fall)
            active_r <= 1'b1;
        else if (sel_rise)
            active_r <= 1'b0;
    end

    // ============================================================
    // Conversion phase: track, hold, then track while reading out
    typedef enum logic [2:0] {
        PH_TRACK = 3'b001,
        PH_HOLD  = 3'b010,
        PH_READ  = 3'b100
    } conv_phase_t;

    conv_phase_t phase_r;
    conv_phase_t phase_nxt;

    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            PH_TRACK: begin
                if (sel_fall) begin
                    phase_nxt = PH_HOLD;
                end
            end
            PH_HOLD: begin
                // Abort leaves hold at once, whatever the mode becomes
                if (sel_rise) begin
                    phase_nxt = PH_TRACK;
                end else if (sclk_rise && rise_cnt_r == sadc_pkg::HOLD_END_RISE - 5'h01) begin
                    phase_nxt = PH_READ;
                end
            end
            PH_READ: begin
                if (sel_fall) begin
                    phase_nxt = PH_HOLD;
                end else if (sel_rise) begin
                    phase_nxt = PH_TRACK;
                end
            end
            default: begin
                phase_nxt = PH_TRACK;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_r <= PH_TRACK;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            holding <= 1'b0;
        end else begin
            holding <= (phase_nxt == PH_HOLD);
        end
    end

    // ============================================================
    // Serial result: zeros lead, code straight binary, MSB first
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_r <= '0;
            out_r   <= 1'b0;
        end else if (sel_fall) begin
            // Dummy frame still shifts but its code is meaningless
            shift_r <= {4'h0, sample_code};
            out_r   <= 1'b0;
        end else if (active_r && sclk_fall) begin
            // Bit n leaves on fall n, host takes it on fall n+1
            out_r   <= shift_r[14];
            shift_r <= {shift_r[14:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            oe_r <= 1'b0;
        else if (sel_fall)
            oe_r <= 1'b1;
        else if (sel_rise)
            oe_r <= 1'b0;
        else if (active_r && sclk_fall && fall_cnt_r == sadc_pkg::LAST_FALL - 5'h01)
            oe_r <= 1'b0;
    end

    assign link.serial_result_out = out_r;
    assign link.serial_result_oe  = oe_r;

    // ============================================================
    // Power mode
    // Mode after deselect depends on how far the frame had got.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            shutdown    <= 1'b0;
            dummy_frame <= 1'b0;
        end else if (sel_fall) begin
            shutdown    <= 1'b0;
            dummy_frame <= shutdown;
        end else if (sel_rise && active_r) begin
            if (fall_cnt_r < sadc_pkg::MODE_GUARD_FALL)
                shutdown <= dummy_frame;
            else if (fall_cnt_r < sadc_pkg::MODE_LOCK_FALL)
                shutdown <= 1'b1;
            else
                shutdown <= 1'b0;
        end
    end

    logic unused_lvl;
    assign unused_lvl = sel_n_lvl ^ sclk_lvl;
endmodule
`default_nettype wire

// ===== include/sadc_pkg.sv
/*
 * Shared constants and types for the serial converter readout link.
 * Assumes both ends run on the same 125 MHz system clock domain style.
 */
package sadc_pkg;
    localparam int unsigned CLK_PERIOD_PS     = 8000;
    localparam int unsigned FRAME_BITS        = 16;
    localparam int unsigned RESULT_BITS       = 12;
    localparam int unsigned LEAD_ZEROS        = 3;
    localparam int unsigned CNT_W             = 5;
    localparam logic [4:0]  HOLD_END_RISE     = 5'h0D;
    localparam logic [4:0]  LAST_FALL         = 5'h10;
    localparam logic [4:0]  MODE_LOCK_FALL    = 5'h0A;
    localparam logic [4:0]  MODE_GUARD_FALL   = 5'h02;
    localparam logic [4:0]  FRAME_CLKS        = 5'h14;
    localparam int unsigned ACQ_TIME_PS       = 350000;
    localparam int unsigned ACQ_CYCLES        = (ACQ_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0]  ACQ_CYCLES_W      = 8'(ACQ_CYCLES);
    localparam logic [7:0]  HALF_PERIOD       = 8'h05;
    localparam logic [7:0]  QUIET_CYCLES      = 8'h08;

    typedef enum logic [2:0] {
        H_IDLE  = 3'b001,
        H_FRAME = 3'b010,
        H_GAP   = 3'b100
    } host_state_t;
endpackage

// ===== include/sadc_if.sv
/*
 * Three-wire link between converter end and host end.
 * Assumes the bench resolves the serial line from its output enable.
 */
`timescale 1ns/1ps
`default_nettype none
interface sadc_if;
    logic frame_sel_n;
    logic sclk;
    logic serial_result_out;
    logic serial_result_oe;

    modport device (
        input  frame_sel_n,
        input  sclk,
        output serial_result_out,
        output serial_result_oe
    );
    modport host (
        output frame_sel_n,
        output sclk,
        input  serial_result_out,
        input  serial_result_oe
    );
endinterface
`default_nettype wire

// ===== rtl/sadc_pin_sync.sv
/*
 * Two-stage synchroniser with edge detection on the second stage.
 * Assumes asynchronous pin input and active-low async reset.
 */
`timescale 1ns/1ps
`default_nettype none
module sadc_pin_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic pin,
    output var  logic level,
    output var  logic rise,
    output var  logic fall
);
    logic meta_r;
    logic sync_r;
    logic prev_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
            prev_r <= RST_VAL;
        end else begin
            meta_r <= pin;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
    assign fall  = ~sync_r & prev_r;
endmodule
`default_nettype wire

// ===== rtl/sadc_host_end.sv
/*
 * Host end: makes the serial clock, frames 20-clock reads, captures
 * the 12-bit result. Assumes the device drives data on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
module sadc_host_end (
    input  wire logic        clk,
    input  wire logic        arst_n,
    sadc_if.host             link,
    input  wire logic        start,
    output var  logic        busy,
    output var  logic [11:0] result,
    output var  logic        result_valid,
    output var  logic        result_dummy
);
    // ============================================================
    // Data input synchroniser
    logic d_meta_r;
    logic d_sync_r;
    logic sel_n_r;
    logic sclk_r;
    logic [7:0] div_r;
    logic [4:0] clks_r;
    logic [15:0] cap_r;
    logic [7:0]  gap_r;
    logic        first_r;
    sadc_pkg::host_state_t st_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            d_meta_r <= 1'b0;
            d_sync_r <= 1'b0;
        end else begin
            d_meta_r <= link.serial_result_out;
            d_sync_r <= d_meta_r;
        end
    end

    // ============================================================
    // Frame sequencer and clock divider
    // Frame select falls with clock high so first fall is a full half later.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r    <= sadc_pkg::H_IDLE;
            sel_n_r <= 1'b1;
            sclk_r  <= 1'b1;
            div_r   <= '0;
            clks_r  <= '0;
            gap_r   <= '0;
            cap_r   <= '0;
            busy    <= 1'b0;
            result  <= '0;
            result_valid <= 1'b0;
            result_dummy <= 1'b0;
            first_r <= 1'b1;
        end else begin
            result_valid <= 1'b0;
            case (st_r)
                sadc_pkg::H_IDLE: begin
                    if (start) begin
                        st_r    <= sadc_pkg::H_FRAME;
                        sel_n_r <= 1'b0;
                        busy    <= 1'b1;
                        div_r   <= '0;
                        clks_r  <= '0;
                    end
                end
                sadc_pkg::H_FRAME: begin
                    if (div_r == sadc_pkg::HALF_PERIOD - 8'h01) begin
                        div_r  <= '0;
                        sclk_r <= ~sclk_r;
                        if (sclk_r) begin
                            // Falling edge: take the bit the device put out
                            // on the previous fall (sync delay of five cycles, one half period)
                            if (clks_r < sadc_pkg::LAST_FALL) begin
                                cap_r <= {cap_r[14:0], d_sync_r};
                            end
                            clks_r <= clks_r + 5'h01;
                            if (clks_r == sadc_pkg::LAST_FALL) begin
                                sel_n_r <= 1'b1;
                            end
                        end else if (clks_r == sadc_pkg::FRAME_CLKS) begin
                            // Stop on the rise so the clock idles high between frames
                            st_r  <= sadc_pkg::H_GAP;
                            gap_r <= '0;
                        end
                    end else begin
                        div_r <= div_r + 8'h01;
                    end
                end
                sadc_pkg::H_GAP: begin
                    if (gap_r == 8'h00) begin
                        // Bits 15..12 lead; the low twelve are the code
                        result       <= cap_r[15-4 -: 12];
                        result_valid <= 1'b1;
                        result_dummy <= first_r;
                        first_r      <= 1'b0;
                    end
                    if (gap_r == sadc_pkg::QUIET_CYCLES + sadc_pkg::ACQ_CYCLES_W) begin
                        st_r <= sadc_pkg::H_IDLE;
                        busy <= 1'b0;
                    end else begin
                        gap_r <= gap_r + 8'h01;
                    end
                end
                default: st_r <= sadc_pkg::H_IDLE;
            endcase
        end
    end

    assign link.frame_sel_n = sel_n_r;
    assign link.sclk        = sclk_r;
endmodule
`default_nettype wire

// ===== verif/sadc_link_monitor.sv
/*
 * Checker for the link between the host end and the converter end.
 * Assumes plain link signals sampled on the 125 MHz system clock.
 */
`timescale 1ns/1ps
`default_nettype none
module sadc_link_monitor (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic frame_sel_n,
    input  wire logic sclk,
    input  wire logic serial_result_out,
    input  wire logic serial_result_oe
);
    // 12.5 link clocks of hold plus the acquisition wait, in system clocks
    localparam int MIN_GAP = 169;
    logic [8:0] gap_r;
    logic       sel_q_r;
    logic       seen_r;
    logic [4:0] sclk_d_r;
    logic       fell_recent;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ==========================================
    // Helpers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_r    <= 9'h000;
            sel_q_r  <= 1'b1;
            seen_r   <= 1'b0;
            sclk_d_r <= 5'h1F;
        end else begin
            sel_q_r  <= frame_sel_n;
            sclk_d_r <= {sclk_d_r[3:0], sclk};
            if (sel_q_r && !frame_sel_n) begin
                gap_r  <= 9'h000;
                seen_r <= 1'b1;
            end else if (gap_r != 9'h1FF) begin
                gap_r <= gap_r + 9'h001;
            end
        end
    end
    // Sync delay means data lags the link clock fall by a few cycles
    assign fell_recent = |(sclk_d_r[4:1] & ~sclk_d_r[3:0]);

    // ==========================================
    // Assertions
    AST_OE_ON: assert property ($fell(frame_sel_n) |-> ##[1:5] serial_result_oe)
        else $error("output not enabled after select fall");
    AST_OE_OFF: assert property ($rose(frame_sel_n) |-> ##[1:5] !serial_result_oe)
        else $error("output still enabled after select rise");
    AST_HIZ_IDLE: assert property (frame_sel_n [*6] |-> !serial_result_oe)
        else $error("output enabled while deselected");
    AST_SHIFT_ON_FALL: assert property (serial_result_oe && $past(serial_result_oe)
        && $changed(serial_result_out) |-> fell_recent)
        else $error("data changed away from a link clock fall");
    AST_LEAD_ZERO: assert property ($rose(serial_result_oe) |-> !serial_result_out [*8])
        else $error("frame does not open with zeros");
    AST_QUIET: assert property ($rose(frame_sel_n) |-> frame_sel_n [*8])
        else $error("quiet interval cut short");
    AST_FRAME_SPACING: assert property ($fell(frame_sel_n) && seen_r |-> gap_r >= MIN_GAP)
        else $error("frame starts too close together");
    AST_HALF_PERIOD: assert property ($fell(sclk) |-> !sclk [*5] ##1 sclk)
        else $error("link clock low phase wrong");
    AST_SEL_AT_HIGH: assert property ($fell(frame_sel_n) |-> sclk)
        else $error("select fell while link clock low");

    COV_FRAME: cover property ($fell(frame_sel_n));
    COV_DRIVE: cover property ($rose(serial_result_oe));
    COV_ONE: cover property (serial_result_oe && serial_result_out);
endmodule
`default_nettype wire

// ===== verif/serial_adc_readout_ctrl_tb.sv
/*
 * Bench: host end reads converter end over one link; the bench itself
 * drives a second converter end. Assumes design files compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module serial_adc_readout_ctrl_tb;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        start = 1'b0;
    logic [11:0] code1 = 12'h000;
    logic [11:0] code2 = 12'h000;
    logic        busy, rvalid, rdummy, hold1, shut1, dum1, hold2, shut2, dum2;
    logic [11:0] result;
    logic [14:0] w;
    int          err_total = 0;
    int          cmp_count = 0;

    sadc_if lnk();
    sadc_if lnk2();
    always #4 clk = ~clk;

    // ==========================================
    // Instances
    sadc_device_end i_sadc_device_end (.clk(clk), .arst_n(arst_n), .link(lnk),
        .sample_code(code1), .holding(hold1), .shutdown(shut1), .dummy_frame(dum1));
    sadc_host_end i_sadc_host_end (.clk(clk), .arst_n(arst_n), .link(lnk), .start(start),
        .busy(busy), .result(result), .result_valid(rvalid), .result_dummy(rdummy));
    sadc_device_end i_sadc_device_end_b (.clk(clk), .arst_n(arst_n), .link(lnk2),
        .sample_code(code2), .holding(hold2), .shutdown(shut2), .dummy_frame(dum2));
    sadc_link_monitor i_sadc_link_monitor (.clk(clk), .arst_n(arst_n),
        .frame_sel_n(lnk.frame_sel_n), .sclk(lnk.sclk),
        .serial_result_out(lnk.serial_result_out), .serial_result_oe(lnk.serial_result_oe));

    // ==========================================
    // Common tasks
    task automatic check(input logic [14:0] seen, input logic [14:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_out();
        err_total++;
        $display("mismatch at %0t: wait ran out", $time);
        end_sim();
    endtask

    // Host end performs one whole read of the given code
    task automatic host_read(input logic [11:0] code, input logic dummy);
        int n;
        n = 0;
        code1 = code;
        while (busy !== 1'b0 && n < 400) begin @(negedge clk); n++; end
        if (n >= 400) wait_out();
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (30) @(negedge clk);
        check({13'h0000, hold1, busy}, 15'h0003);
        n = 0;
        while (rvalid !== 1'b1 && n < 600) begin @(negedge clk); n++; end
        if (n >= 600) wait_out();
        if (!dummy) check(15'(result), 15'(code));
        check(15'(rdummy), 15'(dummy));
        check({11'h000, hold1, lnk.serial_result_oe, shut1, dum1}, 15'h0000);
    endtask

    // Bench frame on the second link: n link clock falls, 80 ns period
    task automatic bb_frame(input int n, input logic [11:0] code);
        code2 = code;
        @(negedge clk);
        lnk2.frame_sel_n = 1'b0;
        repeat (10) @(negedge clk);
        for (int k = 1; k <= n; k++) begin
            lnk2.sclk = 1'b0;
            repeat (5) @(negedge clk);
            lnk2.sclk = 1'b1;
            repeat (4) @(negedge clk);
            // Sample late in the bit so sync delay cannot hide a slip
            if (k < 16) w[15 - k] = lnk2.serial_result_out;
            @(negedge clk);
        end
        lnk2.frame_sel_n = 1'b1;
        repeat (50) @(negedge clk);
    endtask

    // ==========================================
    // Scenarios
    task automatic sc_host_reads();
        host_read(12'hA5C, 1'b1);
        host_read(12'hFFF, 1'b0);
        host_read(12'h000, 1'b0);
        host_read(12'h801, 1'b0);
    endtask

    task automatic sc_word();
        bb_frame(16, 12'hC35);
        check(w, {3'h0, 12'hC35});
        check(15'(lnk2.serial_result_oe), 15'h0000);
        check(15'(hold2), 15'h0000);
    endtask

    task automatic sc_shutdown();
        bb_frame(5, 12'h111);
        check({13'h0, shut2, lnk2.serial_result_oe}, 15'h0002);
        bb_frame(1, 12'h111);
        check(15'(shut2), 15'h0001);
        bb_frame(5, 12'h111);
        check(15'(shut2), 15'h0001);
        repeat (200) @(negedge clk);
        check(15'(shut2), 15'h0001);
        bb_frame(16, 12'h3A6);
        check({13'h0, shut2, dum2}, 15'h0001);
        bb_frame(16, 12'h3A6);
        check({dum2, shut2, w[12:0]}, {2'h0, 13'h03A6});
    endtask

    task automatic sc_abort();
        bb_frame(12, 12'h5AA);
        check({12'h000, hold2, shut2, lnk2.serial_result_oe}, 15'h0000);
        bb_frame(1, 12'h5AA);
        check(15'(shut2), 15'h0000);
    endtask

    initial begin
        lnk2.frame_sel_n = 1'b1;
        lnk2.sclk = 1'b1;
        repeat (16) @(negedge clk);
        arst_n = 1'b1;
        sc_host_reads();
        sc_word();
        sc_shutdown();
        sc_abort();
        end_sim();
    end
endmodule
`default_nettype wire
